// ==== cfg_reg_cell.sv ====
// one configuration register with write mask and calibration load port
// assumes one-cycle write and load strobes on the core clock
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_cell #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0,
    parameter logic [WIDTH-1:0] WR_MASK = '1,
    parameter logic [WIDTH-1:0] LOAD_MASK = '0
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic load_en_in,
    input wire logic [WIDTH-1:0] load_data_in,
    output logic [WIDTH-1:0] value_out
);

    logic [WIDTH-1:0] next_value;
    wire [WIDTH-1:0] loaded = (value_out & ~LOAD_MASK)
                            | (load_data_in & LOAD_MASK);

    // [R14] reserved bits masked
    // a software write beats a calibration load; reserved bits stay zero
    assign next_value = wr_en_in ? (wr_data_in & WR_MASK)
                      : load_en_in ? loaded
                      : value_out;

    // hold value until next write, load or reset
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            value_out <= RESET_VAL;
        else
            value_out <= next_value;
    end

endmodule
`default_nettype wire

// ==== radio_cfg_pkg.sv ====
// constants for the radio front-end and synthesizer configuration bank
// assumes an 8-bit register port with 6-bit addresses on one core clock
package radio_cfg_pkg;

    localparam int NUM_REGS = 7;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // register offsets on the configuration port
    localparam logic [5:0] OFS_RX_FRONTEND_BIAS = 6'h21;
    localparam logic [5:0] OFS_TX_FRONTEND_POWER_SELECT = 6'h22;
    localparam logic [5:0] OFS_SYNTH_CAL_CHARGE_PUMP = 6'h23;
    localparam logic [5:0] OFS_SYNTH_CAL_OSC_CURRENT = 6'h24;
    localparam logic [5:0] OFS_SYNTH_CAL_COARSE_TUNE = 6'h25;
    localparam logic [5:0] OFS_SYNTH_CAL_CONTROL = 6'h26;
    localparam logic [5:0] OFS_RC_OSC_CONFIG_HIGH = 6'h27;

    // slot of each register in the bank
    localparam int IDX_RX = 0;
    localparam int IDX_TX = 1;
    localparam int IDX_CP = 2;
    localparam int IDX_OSC = 3;
    localparam int IDX_COARSE = 4;
    localparam int IDX_CTRL = 5;
    localparam int IDX_RC = 6;

    localparam logic [5:0] REG_OFFSET [NUM_REGS] = '{
        OFS_RX_FRONTEND_BIAS, OFS_TX_FRONTEND_POWER_SELECT,
        OFS_SYNTH_CAL_CHARGE_PUMP, OFS_SYNTH_CAL_OSC_CURRENT,
        OFS_SYNTH_CAL_COARSE_TUNE, OFS_SYNTH_CAL_CONTROL,
        OFS_RC_OSC_CONFIG_HIGH};

    // values after reset
    localparam logic [7:0] RST_RX = 8'h56;
    localparam logic [7:0] RST_TX = 8'h10;
    localparam logic [7:0] RST_CP = 8'hA9;
    localparam logic [7:0] RST_OSC = 8'h0A;
    localparam logic [7:0] RST_COARSE = 8'h20;
    localparam logic [7:0] RST_CTRL = 8'h0D;
    localparam logic [7:0] RST_RC = 8'h41;
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{
        RST_RX, RST_TX, RST_CP, RST_OSC, RST_COARSE, RST_CTRL, RST_RC};

    // read port, power index and skip flag after reset
    localparam logic [7:0] RST_RD_DATA = 8'h00;
    localparam logic RST_RD_VALID = 1'b0;
    localparam logic [2:0] RST_POWER_INDEX = 3'h0;
    localparam logic RST_CP_SKIP = 1'b0;

    // writable bits; reserved bits are cleared in the mask
    localparam logic [7:0] REG_WR_MASK [NUM_REGS] = '{
        8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h3F, 8'h7F, 8'h7F};

    // bits the calibration engine updates
    localparam logic [7:0] REG_LOAD_MASK [NUM_REGS] = '{
        8'h00, 8'h00, 8'h0F, 8'h1F, 8'h3F, 8'h00, 8'h00};

    // field positions (lsb)
    localparam int POS_LNA = 6;
    localparam int POS_AMP_MIX = 4;
    localparam int POS_RX_LO = 2;
    localparam int POS_MIXER = 0;
    localparam int POS_TX_LO = 4;
    localparam int POS_POWER = 0;
    localparam int POS_CAL_CFG = 6;
    localparam int POS_CP_EN = 4;
    localparam int POS_CP_CUR = 0;
    localparam int POS_CORE_H = 5;
    localparam int POS_OSC_CUR = 0;
    localparam int POS_COARSE = 0;
    localparam int POS_CTRL = 0;
    localparam int POS_RC = 0;

    // power table slot used for a zero bit under on-off keying
    localparam logic [2:0] OOK_ZERO_INDEX = 3'h0;

endpackage

// ==== radio_frontend_synth_config_regs.sv ====
// front-end bias, power select, synthesizer calibration and rc settings
// assumes the serial port logic gives one-cycle write and read strobes,
// and the tx path and calibration engine share the core clock
// Notes on behaviour
// [R1] rx bias register: four 2-bit fields, reset 01, 01, 01, 10 from top.
// [R2] rx lo buffer bias sits in bits 3:2 and drives the mixer buffer.
// [R3] tx power select bits 2:0, reset 000, indexes the output power table.
// [R4] on-off keying: zero bit uses entry zero, one bit the selected entry.
// [R5] tx lo buffer bias in bits 5:4, reset 01, drives amplifier buffer.
// [R6] calibration configuration bits 7:6, reset 10, loaded before calibration.
// [R7] charge pump calibration enable bits 5:4, reset 10; zero skips stage.
// [R8] charge pump current result bits 3:0, reset 1001, updated by calibration.
// [R9] oscillator core select bit 5: high core when 1, reset 0.
// [R10] oscillator current result bits 4:0, reset 0x0A; writes override it.
// [R11] coarse tune result bits 5:0, reset 0x20; bits 7:6 reserved.
// [R12] written calibration results are used instead of a new calibration.
// [R13] calibration control bits 6:0, reset 0x0D; bit 7 reserved.
// [R14] reserved bits read zero and ignore writes.
// [R15] fields hold until next write or reset and drive controls always; a calibration load also updates the result fields.
`timescale 1ns/1ps
`default_nettype none
module radio_frontend_synth_config_regs (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic cfg_wr_en_in,
    input wire logic [5:0] cfg_addr_in,
    input wire logic [7:0] cfg_wr_data_in,
    input wire logic cfg_rd_en_in,
    input wire logic cal_load_in,
    input wire logic [3:0] cal_charge_pump_in,
    input wire logic [4:0] cal_osc_current_in,
    input wire logic [5:0] cal_coarse_tune_in,
    input wire logic tx_active_in,
    input wire logic on_off_keying_in,
    input wire logic tx_bit_in,
    output logic [7:0] cfg_rd_data_out,
    output logic cfg_rd_valid_out,
    output logic [1:0] lownoise_amp_bias_out,
    output logic [1:0] amp_to_mixer_bias_out,
    output logic [1:0] rx_lo_buffer_bias_out,
    output logic [1:0] mixer_bias_out,
    output logic [1:0] tx_lo_buffer_bias_out,
    output logic [2:0] power_table_index_out,
    output logic [1:0] cal_config_out,
    output logic [1:0] charge_pump_cal_enable_out,
    output logic charge_pump_cal_skip_out,
    output logic [3:0] charge_pump_current_out,
    output logic osc_core_high_select_out,
    output logic [4:0] osc_current_out,
    output logic [5:0] coarse_tune_out,
    output logic [6:0] cal_control_out,
    output logic [6:0] rc_osc_config_out
);

    localparam int N = radio_cfg_pkg::NUM_REGS;

    logic [7:0] regs [N];
    logic [7:0] load_data [N];
    logic [N-1:0] wr_hit;
    logic [N-1:0] rd_hit;
    logic [7:0] rd_chain [N+1];
    logic [7:0] next_rd_data;
    logic [2:0] next_power_index;
    logic ook_zero;

    // calibration results placed at their register positions
    assign load_data[radio_cfg_pkg::IDX_RX] = 8'h00;
    assign load_data[radio_cfg_pkg::IDX_TX] = 8'h00;
    assign load_data[radio_cfg_pkg::IDX_CP] = {4'h0, cal_charge_pump_in};
    assign load_data[radio_cfg_pkg::IDX_OSC] = {3'h0, cal_osc_current_in};
    assign load_data[radio_cfg_pkg::IDX_COARSE] = {2'h0, cal_coarse_tune_in};
    assign load_data[radio_cfg_pkg::IDX_CTRL] = 8'h00;
    assign load_data[radio_cfg_pkg::IDX_RC] = 8'h00;

    assign rd_chain[0] = 8'h00;

    // address decode, register cells and read selection
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_reg
            assign wr_hit[i] = cfg_wr_en_in
                             && cfg_addr_in == radio_cfg_pkg::REG_OFFSET[i];
            assign rd_hit[i] = cfg_addr_in == radio_cfg_pkg::REG_OFFSET[i];
            assign rd_chain[i+1] = rd_chain[i]
                                 | (rd_hit[i] ? regs[i] : 8'h00);
            // [R1] [R12] [R14] [R15] reset, masks, overrides
            cfg_reg_cell #(
                .WIDTH(8),
                .RESET_VAL(radio_cfg_pkg::REG_RESET[i]),
                .WR_MASK(radio_cfg_pkg::REG_WR_MASK[i]),
                .LOAD_MASK(radio_cfg_pkg::REG_LOAD_MASK[i])
            ) u_cell (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .wr_en_in(wr_hit[i]),
                .wr_data_in(cfg_wr_data_in),
                .load_en_in(cal_load_in),
                .load_data_in(load_data[i]),
                .value_out(regs[i])
            );
        end
    endgenerate

    // [R14] unmapped addresses read zero
    assign next_rd_data = cfg_rd_en_in ? rd_chain[N] : 8'h00;

    // read data registered one cycle after the strobe
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            cfg_rd_data_out <= radio_cfg_pkg::RST_RD_DATA;
            cfg_rd_valid_out <= radio_cfg_pkg::RST_RD_VALID;
        end
        else
        begin
            cfg_rd_data_out <= next_rd_data;
            cfg_rd_valid_out <= cfg_rd_en_in;
        end
    end

    // [R1] [R2] rx bias fields
    assign lownoise_amp_bias_out =
        regs[radio_cfg_pkg::IDX_RX][radio_cfg_pkg::POS_LNA +: 2];
    assign amp_to_mixer_bias_out =
        regs[radio_cfg_pkg::IDX_RX][radio_cfg_pkg::POS_AMP_MIX +: 2];
    assign rx_lo_buffer_bias_out =
        regs[radio_cfg_pkg::IDX_RX][radio_cfg_pkg::POS_RX_LO +: 2];
    assign mixer_bias_out =
        regs[radio_cfg_pkg::IDX_RX][radio_cfg_pkg::POS_MIXER +: 2];

    // [R5] tx lo buffer field
    assign tx_lo_buffer_bias_out =
        regs[radio_cfg_pkg::IDX_TX][radio_cfg_pkg::POS_TX_LO +: 2];

    // [R6] [R7] [R8] charge pump register fields
    assign cal_config_out =
        regs[radio_cfg_pkg::IDX_CP][radio_cfg_pkg::POS_CAL_CFG +: 2];
    assign charge_pump_cal_enable_out =
        regs[radio_cfg_pkg::IDX_CP][radio_cfg_pkg::POS_CP_EN +: 2];
    assign charge_pump_current_out =
        regs[radio_cfg_pkg::IDX_CP][radio_cfg_pkg::POS_CP_CUR +: 4];

    // [R9] [R10] [R11] oscillator fields
    assign osc_core_high_select_out =
        regs[radio_cfg_pkg::IDX_OSC][radio_cfg_pkg::POS_CORE_H];
    assign osc_current_out =
        regs[radio_cfg_pkg::IDX_OSC][radio_cfg_pkg::POS_OSC_CUR +: 5];
    assign coarse_tune_out =
        regs[radio_cfg_pkg::IDX_COARSE][radio_cfg_pkg::POS_COARSE +: 6];

    // [R13] calibration control and rc settings
    assign cal_control_out =
        regs[radio_cfg_pkg::IDX_CTRL][radio_cfg_pkg::POS_CTRL +: 7];
    assign rc_osc_config_out =
        regs[radio_cfg_pkg::IDX_RC][radio_cfg_pkg::POS_RC +: 7];

    // [R4] zero bit under on-off keying picks entry zero
    assign ook_zero = tx_active_in && on_off_keying_in && !tx_bit_in;
    // [R3] otherwise the selected table slot
    assign next_power_index = ook_zero ? radio_cfg_pkg::OOK_ZERO_INDEX
        : regs[radio_cfg_pkg::IDX_TX][radio_cfg_pkg::POS_POWER +: 3];

    // power index and charge pump skip flag
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            power_table_index_out <= radio_cfg_pkg::RST_POWER_INDEX;
            charge_pump_cal_skip_out <= radio_cfg_pkg::RST_CP_SKIP;
        end
        else
        begin
            power_table_index_out <= next_power_index;
            // [R7] enable of zero skips the stage
            charge_pump_cal_skip_out <= charge_pump_cal_enable_out == 2'h0;
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // checks on reset, write, load, read, power index and skip flag behaviour
    a_rx_reset_value: assert property ( // [R1]
        @(posedge ref_clk_in) $rose(rst_n_in) |-> lownoise_amp_bias_out == 2'h1
        && amp_to_mixer_bias_out == 2'h1 && rx_lo_buffer_bias_out == 2'h1
        && mixer_bias_out == 2'h2)
        else $error("rx bias reset value wrong");

    a_rx_lo_write: assert property ( // [R2]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_RX_FRONTEND_BIAS
        |=> rx_lo_buffer_bias_out == $past(cfg_wr_data_in[3:2]))
        else $error("rx lo buffer field not written");

    a_power_index_plain: assert property ( // [R3]
        !on_off_keying_in
        |=> power_table_index_out == $past(
            regs[radio_cfg_pkg::IDX_TX][radio_cfg_pkg::POS_POWER +: 3]))
        else $error("power index not from register");

    a_ook_zero_bit: assert property ( // [R4]
        tx_active_in && on_off_keying_in && !tx_bit_in
        |=> power_table_index_out == 3'h0)
        else $error("zero bit did not use entry zero");

    a_ook_one_bit: assert property ( // [R4]
        tx_active_in && on_off_keying_in && tx_bit_in
        |=> power_table_index_out == $past(
            regs[radio_cfg_pkg::IDX_TX][2:0]))
        else $error("one bit did not use selected entry");

    a_tx_lo_write: assert property ( // [R5]
        cfg_wr_en_in
        && cfg_addr_in == radio_cfg_pkg::OFS_TX_FRONTEND_POWER_SELECT
        |=> tx_lo_buffer_bias_out == $past(cfg_wr_data_in[5:4]))
        else $error("tx lo buffer field not written");

    a_cal_cfg_write: assert property ( // [R6]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_CHARGE_PUMP
        |=> cal_config_out == $past(cfg_wr_data_in[7:6]))
        else $error("calibration configuration not written");

    a_cp_skip_flag: assert property ( // [R7]
        charge_pump_cal_enable_out == 2'h0 && $stable(charge_pump_cal_enable_out)
        |-> charge_pump_cal_skip_out)
        else $error("skip flag not raised for zero enable");

    a_cp_cal_load: assert property ( // [R8]
        cal_load_in && !cfg_wr_en_in
        |=> charge_pump_current_out == $past(cal_charge_pump_in)
        && osc_current_out == $past(cal_osc_current_in))
        else $error("calibration result not loaded");

    a_core_select: assert property ( // [R9]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_OSC_CURRENT
        |=> osc_core_high_select_out == $past(cfg_wr_data_in[5]))
        else $error("core select not written");

    a_hop_override: assert property ( // [R10]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_OSC_CURRENT
        |=> osc_current_out == $past(cfg_wr_data_in[4:0]))
        else $error("override of current result lost");

    a_coarse_load: assert property ( // [R11]
        cal_load_in && !cfg_wr_en_in
        |=> coarse_tune_out == $past(cal_coarse_tune_in))
        else $error("coarse tune result not loaded");

    a_hop_restore: assert property ( // [R12]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_COARSE_TUNE
        ##1 !cal_load_in && !cfg_wr_en_in
        |=> coarse_tune_out == $past(cfg_wr_data_in[5:0], 2))
        else $error("saved coarse tune not kept");

    a_ctrl_write: assert property ( // [R13]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_CONTROL
        |=> cal_control_out == $past(cfg_wr_data_in[6:0]))
        else $error("calibration control not written");

    a_reserved_zero: assert property ( // [R14]
        cfg_rd_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_COARSE_TUNE
        |=> cfg_rd_valid_out && cfg_rd_data_out[7:6] == 2'h0)
        else $error("reserved bits read nonzero");

    a_field_hold: assert property ( // [R15]
        !cfg_wr_en_in && !cal_load_in
        |=> $stable(cal_control_out) && $stable(coarse_tune_out)
        && $stable(rc_osc_config_out))
        else $error("field changed without write");

    a_rx_all_write: assert property ( // [R1]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_RX_FRONTEND_BIAS
        |=> {lownoise_amp_bias_out, amp_to_mixer_bias_out,
        rx_lo_buffer_bias_out, mixer_bias_out} == $past(cfg_wr_data_in))
        else $error("rx bias fields not written");

    a_cp_skip_clear: assert property ( // [R7]
        charge_pump_cal_enable_out != 2'h0 |=> !charge_pump_cal_skip_out)
        else $error("skip flag raised for nonzero enable");

    a_tx_reserved_zero: assert property ( // [R14]
        cfg_rd_en_in
        && cfg_addr_in == radio_cfg_pkg::OFS_TX_FRONTEND_POWER_SELECT
        |=> cfg_rd_data_out[7:6] == 2'h0 && cfg_rd_data_out[3] == 1'b0)
        else $error("tx reserved bits read nonzero");

    a_osc_reserved_zero: assert property ( // [R14]
        cfg_rd_en_in && cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_OSC_CURRENT
        |=> cfg_rd_data_out[7:6] == 2'h0)
        else $error("oscillator reserved bits read nonzero");

    a_top_bit_reserved: assert property ( // [R14]
        cfg_rd_en_in && (cfg_addr_in == radio_cfg_pkg::OFS_SYNTH_CAL_CONTROL
        || cfg_addr_in == radio_cfg_pkg::OFS_RC_OSC_CONFIG_HIGH)
        |=> cfg_rd_data_out[7] == 1'b0)
        else $error("top reserved bit reads nonzero");

    a_unmapped_read: assert property ( // [R14]
        cfg_rd_en_in && rd_hit == '0
        |=> cfg_rd_valid_out && cfg_rd_data_out == 8'h00)
        else $error("unmapped address read nonzero");

    a_rc_write: assert property ( // [R15]
        cfg_wr_en_in && cfg_addr_in == radio_cfg_pkg::OFS_RC_OSC_CONFIG_HIGH
        |=> rc_osc_config_out == $past(cfg_wr_data_in[6:0]))
        else $error("rc configuration not written");

endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench for the radio front-end and synthesizer bank
// assumes a 200 MHz core clock and the one-cycle strobe register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cfg_wr_en_in = 1'b0;
    logic [5:0] cfg_addr_in = 6'h00;
    logic [7:0] cfg_wr_data_in = 8'h00;
    logic cfg_rd_en_in = 1'b0;
    logic cal_load_in = 1'b0;
    logic [3:0] cal_charge_pump_in = 4'h0;
    logic [4:0] cal_osc_current_in = 5'h00;
    logic [5:0] cal_coarse_tune_in = 6'h00;
    logic tx_active_in = 1'b0;
    logic on_off_keying_in = 1'b0;
    logic tx_bit_in = 1'b0;
    logic [7:0] cfg_rd_data_out;
    logic cfg_rd_valid_out, charge_pump_cal_skip_out, osc_core_high_select_out;
    logic [1:0] lownoise_amp_bias_out, amp_to_mixer_bias_out;
    logic [1:0] rx_lo_buffer_bias_out, mixer_bias_out, tx_lo_buffer_bias_out;
    logic [1:0] cal_config_out, charge_pump_cal_enable_out;
    logic [2:0] power_table_index_out;
    logic [3:0] charge_pump_current_out;
    logic [4:0] osc_current_out;
    logic [5:0] coarse_tune_out;
    logic [6:0] cal_control_out, rc_osc_config_out;
    int n_mismatch = 0;
    int checks = 0;
    // expected reset and all-ones readback, offsets 0x21 upward
    logic [7:0] exp_rst [7] = '{8'h56, 8'h10, 8'hA9, 8'h0A, 8'h20, 8'h0D,
        8'h41};
    logic [7:0] exp_ones [7] = '{8'hFF, 8'h37, 8'hFF, 8'h3F, 8'h3F, 8'h7F,
        8'h7F};

    radio_frontend_synth_config_regs dut (
        .ref_clk_in, .rst_n_in, .cfg_wr_en_in, .cfg_addr_in, .cfg_wr_data_in,
        .cfg_rd_en_in, .cal_load_in, .cal_charge_pump_in, .cal_osc_current_in,
        .cal_coarse_tune_in, .tx_active_in, .on_off_keying_in, .tx_bit_in,
        .cfg_rd_data_out, .cfg_rd_valid_out, .lownoise_amp_bias_out,
        .amp_to_mixer_bias_out, .rx_lo_buffer_bias_out, .mixer_bias_out,
        .tx_lo_buffer_bias_out, .power_table_index_out, .cal_config_out,
        .charge_pump_cal_enable_out, .charge_pump_cal_skip_out,
        .charge_pump_current_out, .osc_core_high_select_out,
        .osc_current_out, .coarse_tune_out, .cal_control_out,
        .rc_osc_config_out
    );

    // core clock, 5 ns period
    always #2.5 ref_clk_in = ~ref_clk_in;

    task automatic results();
        if (n_mismatch == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // move to 1 ns after the next rising edge
    task automatic step();
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        cfg_wr_en_in = 1'b1;
        cfg_addr_in = a;
        cfg_wr_data_in = d;
        step();
        cfg_wr_en_in = 1'b0;
        step();
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        cfg_rd_en_in = 1'b1;
        cfg_addr_in = a;
        step();
        cfg_rd_en_in = 1'b0;
        chk("read valid", 8'h01, {7'h00, cfg_rd_valid_out});
        chk("read data", exp, cfg_rd_data_out);
        step();
        chk("read valid low", 8'h00, {7'h00, cfg_rd_valid_out});
    endtask

    // reset, then reset values on the port and on every field output
    task automatic t_reset();
        rst_n_in = 1'b0;
        repeat (4) step();
        rst_n_in = 1'b1;
        chk("rx fields", 8'h56, {lownoise_amp_bias_out, amp_to_mixer_bias_out,
            rx_lo_buffer_bias_out, mixer_bias_out});
        chk("tx lo bias", 8'h01, {6'h00, tx_lo_buffer_bias_out});
        chk("power index", 8'h00, {5'h00, power_table_index_out});
        chk("cp fields", 8'hA9, {cal_config_out, charge_pump_cal_enable_out,
            charge_pump_current_out});
        chk("osc fields", 8'h0A, {2'h0, osc_core_high_select_out,
            osc_current_out});
        chk("coarse tune", 8'h20, {2'h0, coarse_tune_out});
        chk("cal control", 8'h0D, {1'h0, cal_control_out});
        chk("rc config", 8'h41, {1'h0, rc_osc_config_out});
        chk("cp skip", 8'h00, {7'h00, charge_pump_cal_skip_out});
        for (int i = 0; i < 7; i++)
            rd(6'(6'h21 + i), exp_rst[i]);
    endtask

    // calibration load, hop override writes, write beating a load
    task automatic t_cal();
        cal_load_in = 1'b1;
        cal_charge_pump_in = 4'h3;
        cal_osc_current_in = 5'h15;
        cal_coarse_tune_in = 6'h2A;
        step();
        cal_load_in = 1'b0;
        chk("cp current", 8'h03, {4'h0, charge_pump_current_out});
        rd(6'h23, 8'hA3);
        rd(6'h24, 8'h15);
        rd(6'h25, 8'h2A);
        wr(6'h23, 8'hA7);
        wr(6'h24, 8'h2C);
        wr(6'h25, 8'h11);
        chk("hop cp", 8'h07, {4'h0, charge_pump_current_out});
        chk("hop osc", 8'h2C, {2'h0, osc_core_high_select_out,
            osc_current_out});
        chk("hop coarse", 8'h11, {2'h0, coarse_tune_out});
        cfg_wr_en_in = 1'b1;
        cfg_addr_in = 6'h25;
        cfg_wr_data_in = 8'h05;
        cal_load_in = 1'b1;
        cal_charge_pump_in = 4'h0;
        cal_osc_current_in = 5'h00;
        cal_coarse_tune_in = 6'h3F;
        step();
        cfg_wr_en_in = 1'b0;
        cal_load_in = 1'b0;
        chk("write wins", 8'h05, {2'h0, coarse_tune_out});
        chk("load cp", 8'h00, {4'h0, charge_pump_current_out});
        chk("load osc", 8'h20, {2'h0, osc_core_high_select_out,
            osc_current_out});
        // let an edge pass before the next task raises the strobe again
        step();
    endtask

    // power index under on-off keying and plain transmission
    task automatic t_ook();
        wr(6'h22, 8'h25);
        chk("tx lo bias", 8'h02, {6'h00, tx_lo_buffer_bias_out});
        tx_active_in = 1'b1;
        on_off_keying_in = 1'b1;
        tx_bit_in = 1'b0;
        step();
        chk("ook zero", 8'h00, {5'h00, power_table_index_out});
        tx_bit_in = 1'b1;
        step();
        chk("ook one", 8'h05, {5'h00, power_table_index_out});
        on_off_keying_in = 1'b0;
        tx_bit_in = 1'b0;
        step();
        chk("plain index", 8'h05, {5'h00, power_table_index_out});
        tx_active_in = 1'b0;
    endtask

    // charge-pump stage skip follows an all-zero enable field
    task automatic t_skip();
        wr(6'h23, 8'h80);
        chk("skip set", 8'h01, {7'h00, charge_pump_cal_skip_out});
        wr(6'h23, 8'h90);
        chk("skip clear", 8'h00, {7'h00, charge_pump_cal_skip_out});
    endtask

    // all-ones writes, reserved bits, unmapped places, rx lo field
    task automatic t_ones();
        for (int i = 0; i < 7; i++)
        begin
            wr(6'(6'h21 + i), 8'hFF);
            rd(6'(6'h21 + i), exp_ones[i]);
        end
        chk("cp ones", 8'hFF, {cal_config_out, charge_pump_cal_enable_out,
            charge_pump_current_out});
        chk("osc ones", 8'h3F, {2'h0, osc_core_high_select_out,
            osc_current_out});
        chk("coarse ones", 8'h3F, {2'h0, coarse_tune_out});
        chk("ctrl ones", 8'h7F, {1'h0, cal_control_out});
        chk("rc ones", 8'h7F, {1'h0, rc_osc_config_out});
        chk("tx lo ones", 8'h03, {6'h00, tx_lo_buffer_bias_out});
        chk("index ones", 8'h07, {5'h00, power_table_index_out});
        wr(6'h20, 8'hFF);
        rd(6'h20, 8'h00);
        rd(6'h28, 8'h00);
        wr(6'h21, 8'h08);
        chk("rx lo only", 8'h08, {lownoise_amp_bias_out, amp_to_mixer_bias_out,
            rx_lo_buffer_bias_out, mixer_bias_out});
    endtask

    // main sequence, ending with a reset in mid-run
    initial
    begin
        t_reset();
        t_cal();
        t_ook();
        t_skip();
        t_ones();
        t_reset();
        results();
    end

    // watchdog, far beyond the hundred or so cycles the tests take
    initial
    begin
        #20000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
